/* logic/uart_baud_loop.sv */
/*
 One serial channel: register file, 8N1 transmitter and receiver, baud
 divisor and internal loop-back of the serial and modem paths.
 Assumes the CPU strobes are synchronous to i_ref_clk, one cycle each.
*/
`timescale 1ns/100ps
module uart_baud_loop (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_cs_n,
	input wire logic i_wr_n,
	input wire logic i_rd_n,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	input wire logic i_rx,
	output logic o_tx,
	input wire logic i_cts_n,
	input wire logic i_dsr_n,
	input wire logic i_ri_n,
	input wire logic i_cd_n,
	output logic o_dtr_n,
	output logic o_rts_n,
	output logic o_irq
);
	baud_if bif();

	logic [3:0] irq_en_q, irq_en_d;
	logic [7:0] line_ctl_q, line_ctl_d;
	logic [4:0] modem_ctl_q, modem_ctl_d;
	logic [7:0] spr_q, spr_d;
	logic [7:0] div_lo_q, div_lo_d;
	logic [7:0] div_hi_q, div_hi_d;
	logic [7:0] tx_hold_q, tx_hold_d;
	logic tx_full_q, tx_full_d;
	logic [7:0] tsr_q, tsr_d;
	uart_bl_pkg::tx_state_t tx_st_q, tx_st_d;
	logic [3:0] tx_ph_q, tx_ph_d;
	logic [2:0] tx_bit_q, tx_bit_d;
	logic tx_line_q, tx_line_d;
	logic [7:0] rx_hold_q, rx_hold_d;
	logic dr_q, dr_d;
	logic oe_q, oe_d;
	logic fe_q, fe_d;
	uart_bl_pkg::rx_state_t rx_st_q, rx_st_d;
	logic [3:0] rx_ph_q, rx_ph_d;
	logic [2:0] rx_bit_q, rx_bit_d;
	logic [7:0] rx_sh_q, rx_sh_d;
	logic [3:0] msr_lvl_q, msr_lvl_d;
	logic [3:0] msr_dlt_q, msr_dlt_d;
	logic [7:0] rdata_q, rdata_d;
	logic tx_pin_q, tx_pin_d;
	logic dtr_n_q, dtr_n_d;
	logic rts_n_q, rts_n_d;
	logic irq_q, irq_d;

	logic wr, rd, div_acc, loop, tick, rx_in;
	logic [3:0] lvl_now;
	logic [3:0] isr_code;
	logic [7:0] lsr;

	function automatic logic [3:0] step_phase(input logic [3:0] ph, input logic t);
		step_phase = t ? 4'(ph + 4'h1) : ph;
	endfunction

	assign bif.divisor = {div_hi_q, div_lo_q};

	baud_gen u_baud_gen (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.bus(bif.gen)
	);

	always_comb begin
		wr = !i_cs_n && !i_wr_n;
		rd = !i_cs_n && !i_rd_n;
		div_acc = line_ctl_q[uart_bl_pkg::LINE_DIV_ACCESS_BIT];
		loop = modem_ctl_q[uart_bl_pkg::MODEM_LOOP_BIT];
		tick = bif.tick16;
		rx_in = loop ? tx_line_q : i_rx;
		// Levels kept active high: bit0 CTS, bit1 DSR, bit2 RI, bit3 CD
		if (loop) begin
			lvl_now = modem_ctl_q[3:0];
		end else begin
			lvl_now = {~i_cd_n, ~i_ri_n, ~i_dsr_n, ~i_cts_n};
		end

		irq_en_d = irq_en_q;
		line_ctl_d = line_ctl_q;
		modem_ctl_d = modem_ctl_q;
		spr_d = spr_q;
		div_lo_d = div_lo_q;
		div_hi_d = div_hi_q;
		tx_hold_d = tx_hold_q;
		tx_full_d = tx_full_q;
		tsr_d = tsr_q;
		tx_st_d = tx_st_q;
		tx_ph_d = tx_ph_q;
		tx_bit_d = tx_bit_q;
		tx_line_d = tx_line_q;
		rx_hold_d = rx_hold_q;
		dr_d = dr_q;
		oe_d = oe_q;
		fe_d = fe_q;
		rx_st_d = rx_st_q;
		rx_ph_d = rx_ph_q;
		rx_bit_d = rx_bit_q;
		rx_sh_d = rx_sh_q;
		rdata_d = rdata_q;

		lsr = {1'b0, !tx_full_q && tx_st_q == uart_bl_pkg::TX_IDLE, !tx_full_q, 1'b0,
			fe_q, 1'b0, oe_q, dr_q};

		// Priority: line, receive, transmit, modem
		if (irq_en_q[uart_bl_pkg::IRQ_EN_LINE_BIT] && (oe_q || fe_q)) begin
			isr_code = uart_bl_pkg::ISR_LINE;
		end else if (irq_en_q[uart_bl_pkg::IRQ_EN_RX_BIT] && dr_q) begin
			isr_code = uart_bl_pkg::ISR_RX;
		end else if (irq_en_q[uart_bl_pkg::IRQ_EN_TX_BIT] && !tx_full_q) begin
			isr_code = uart_bl_pkg::ISR_TX_EMPTY;
		end else if (irq_en_q[uart_bl_pkg::IRQ_EN_MODEM_BIT] && |msr_dlt_q) begin
			isr_code = uart_bl_pkg::ISR_MODEM;
		end else begin
			isr_code = uart_bl_pkg::ISR_NONE;
		end

		// Reads and their clearing side effects; hardware sets below win
		msr_dlt_d = msr_dlt_q;
		if (rd) begin
			unique case (i_addr)
				uart_bl_pkg::ADDR_DATA: begin
					if (div_acc) begin
						rdata_d = div_lo_q;
					end else begin
						rdata_d = rx_hold_q;
						dr_d = 1'b0;
					end
				end
				uart_bl_pkg::ADDR_IRQ_EN: rdata_d = div_acc ? div_hi_q : {4'h0, irq_en_q};
				uart_bl_pkg::ADDR_ISR: rdata_d = {4'h0, isr_code};
				uart_bl_pkg::ADDR_LINE_CTL: rdata_d = line_ctl_q;
				uart_bl_pkg::ADDR_MODEM_CTL: rdata_d = {3'h0, modem_ctl_q};
				uart_bl_pkg::ADDR_LSR: begin
					rdata_d = lsr;
					oe_d = 1'b0;
					fe_d = 1'b0;
				end
				uart_bl_pkg::ADDR_MSR: begin
					rdata_d = {msr_lvl_q, msr_dlt_q};
					msr_dlt_d = 4'h0;
				end
				uart_bl_pkg::ADDR_SPR: rdata_d = spr_q;
			endcase
		end
		msr_lvl_d = lvl_now;
		msr_dlt_d = msr_dlt_d | (lvl_now ^ msr_lvl_q);

		// Transmitter, one bit per sixteen ticks
		unique case (tx_st_q)
			uart_bl_pkg::TX_IDLE: begin
				tx_line_d = 1'b1;
				// Start on a tick so the start bit spans exactly sixteen ticks
				if (tx_full_q && tick) begin
					tsr_d = tx_hold_q;
					tx_full_d = 1'b0;
					tx_line_d = 1'b0;
					tx_ph_d = 4'h0;
					tx_st_d = uart_bl_pkg::TX_START;
				end
			end
			uart_bl_pkg::TX_START: begin
				tx_line_d = 1'b0;
				tx_ph_d = step_phase(tx_ph_q, tick);
				if (tick && tx_ph_q == uart_bl_pkg::PHASE_LAST) begin
					tx_bit_d = 3'h0;
					tx_line_d = tsr_q[0];
					tx_st_d = uart_bl_pkg::TX_DATA;
				end
			end
			uart_bl_pkg::TX_DATA: begin
				tx_ph_d = step_phase(tx_ph_q, tick);
				if (tick && tx_ph_q == uart_bl_pkg::PHASE_LAST) begin
					tsr_d = {1'b1, tsr_q[7:1]};
					tx_bit_d = 3'(tx_bit_q + 3'h1);
					tx_line_d = tsr_q[1];
					if (tx_bit_q == uart_bl_pkg::LAST_BIT) begin
						tx_line_d = 1'b1;
						tx_st_d = uart_bl_pkg::TX_STOP;
					end
				end
			end
			uart_bl_pkg::TX_STOP: begin
				tx_line_d = 1'b1;
				tx_ph_d = step_phase(tx_ph_q, tick);
				if (tick && tx_ph_q == uart_bl_pkg::PHASE_LAST) begin
					tx_st_d = uart_bl_pkg::TX_IDLE;
				end
			end
		endcase

		// Receiver, sampling mid-bit
		unique case (rx_st_q)
			uart_bl_pkg::RX_IDLE: begin
				if (!rx_in) begin
					rx_ph_d = 4'h0;
					rx_st_d = uart_bl_pkg::RX_START;
				end
			end
			uart_bl_pkg::RX_START: begin
				rx_ph_d = step_phase(rx_ph_q, tick);
				if (tick && rx_ph_q == uart_bl_pkg::PHASE_MID) begin
					// Short low pulse is noise, not a start bit
					rx_ph_d = 4'h0;
					rx_bit_d = 3'h0;
					rx_st_d = rx_in ? uart_bl_pkg::RX_IDLE : uart_bl_pkg::RX_DATA;
				end
			end
			uart_bl_pkg::RX_DATA: begin
				rx_ph_d = step_phase(rx_ph_q, tick);
				if (tick && rx_ph_q == uart_bl_pkg::PHASE_LAST) begin
					rx_sh_d = {rx_in, rx_sh_q[7:1]};
					rx_bit_d = 3'(rx_bit_q + 3'h1);
					if (rx_bit_q == uart_bl_pkg::LAST_BIT) begin
						rx_st_d = uart_bl_pkg::RX_STOP;
					end
				end
			end
			uart_bl_pkg::RX_STOP: begin
				rx_ph_d = step_phase(rx_ph_q, tick);
				if (tick && rx_ph_q == uart_bl_pkg::PHASE_LAST) begin
					rx_hold_d = rx_sh_q;
					oe_d = oe_d | dr_q;
					dr_d = 1'b1;
					fe_d = fe_d | !rx_in;
					rx_st_d = uart_bl_pkg::RX_IDLE;
				end
			end
		endcase

		// Writes; a transmit write in the same cycle as a load wins the flag
		if (wr) begin
			unique case (i_addr)
				uart_bl_pkg::ADDR_DATA: begin
					if (div_acc) begin
						div_lo_d = i_wdata;
					end else begin
						tx_hold_d = i_wdata;
						tx_full_d = 1'b1;
					end
				end
				uart_bl_pkg::ADDR_IRQ_EN: begin
					if (div_acc) begin
						div_hi_d = i_wdata;
					end else begin
						irq_en_d = i_wdata[3:0];
					end
				end
				uart_bl_pkg::ADDR_LINE_CTL: line_ctl_d = i_wdata;
				uart_bl_pkg::ADDR_MODEM_CTL: modem_ctl_d = i_wdata[4:0];
				uart_bl_pkg::ADDR_SPR: spr_d = i_wdata;
				uart_bl_pkg::ADDR_ISR, uart_bl_pkg::ADDR_LSR, uart_bl_pkg::ADDR_MSR: begin
				end
			endcase
		end

		tx_pin_d = loop | tx_line_d;
		dtr_n_d = !(modem_ctl_q[uart_bl_pkg::MODEM_DTR_BIT] && !loop);
		rts_n_d = !(modem_ctl_q[uart_bl_pkg::MODEM_RTS_BIT] && !loop);
		irq_d = modem_ctl_q[uart_bl_pkg::MODEM_INT_EN_BIT] && isr_code != uart_bl_pkg::ISR_NONE;
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_en_q <= uart_bl_pkg::IRQ_EN_RST;
			line_ctl_q <= uart_bl_pkg::LINE_CTL_RST;
			modem_ctl_q <= uart_bl_pkg::MODEM_CTL_RST;
			spr_q <= uart_bl_pkg::SPR_RST;
			div_lo_q <= uart_bl_pkg::DIV_RST[7:0];
			div_hi_q <= uart_bl_pkg::DIV_RST[15:8];
			tx_hold_q <= 8'h00;
			tx_full_q <= 1'b0;
			tsr_q <= 8'h00;
			tx_st_q <= uart_bl_pkg::TX_IDLE;
			tx_ph_q <= 4'h0;
			tx_bit_q <= 3'h0;
			tx_line_q <= 1'b1;
			rx_hold_q <= 8'h00;
			dr_q <= 1'b0;
			oe_q <= 1'b0;
			fe_q <= 1'b0;
			rx_st_q <= uart_bl_pkg::RX_IDLE;
			rx_ph_q <= 4'h0;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			msr_lvl_q <= 4'h0;
			msr_dlt_q <= 4'h0;
			rdata_q <= 8'h00;
			tx_pin_q <= 1'b1;
			dtr_n_q <= 1'b1;
			rts_n_q <= 1'b1;
			irq_q <= 1'b0;
		end else begin
			irq_en_q <= irq_en_d;
			line_ctl_q <= line_ctl_d;
			modem_ctl_q <= modem_ctl_d;
			spr_q <= spr_d;
			div_lo_q <= div_lo_d;
			div_hi_q <= div_hi_d;
			tx_hold_q <= tx_hold_d;
			tx_full_q <= tx_full_d;
			tsr_q <= tsr_d;
			tx_st_q <= tx_st_d;
			tx_ph_q <= tx_ph_d;
			tx_bit_q <= tx_bit_d;
			tx_line_q <= tx_line_d;
			rx_hold_q <= rx_hold_d;
			dr_q <= dr_d;
			oe_q <= oe_d;
			fe_q <= fe_d;
			rx_st_q <= rx_st_d;
			rx_ph_q <= rx_ph_d;
			rx_bit_q <= rx_bit_d;
			rx_sh_q <= rx_sh_d;
			msr_lvl_q <= msr_lvl_d;
			msr_dlt_q <= msr_dlt_d;
			rdata_q <= rdata_d;
			tx_pin_q <= tx_pin_d;
			dtr_n_q <= dtr_n_d;
			rts_n_q <= rts_n_d;
			irq_q <= irq_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_tx = tx_pin_q;
	assign o_dtr_n = dtr_n_q;
	assign o_rts_n = rts_n_q;
	assign o_irq = irq_q;
endmodule

/* logic/uart_bl_pkg.sv */
/*
 Shared constants and types for the serial channel baud generator and loop-back logic.
 Assumes a single device clock; register offsets are the three CPU address lines.
*/
package uart_bl_pkg;

	// Register offsets, general set
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_IRQ_EN = 3'h1;
	localparam logic [2:0] ADDR_ISR = 3'h2;
	localparam logic [2:0] ADDR_LINE_CTL = 3'h3;
	localparam logic [2:0] ADDR_MODEM_CTL = 3'h4;
	localparam logic [2:0] ADDR_LSR = 3'h5;
	localparam logic [2:0] ADDR_MSR = 3'h6;
	localparam logic [2:0] ADDR_SPR = 3'h7;
	// Divisor set, seen while the divisor access bit is one
	localparam logic [2:0] ADDR_DIV_LO = 3'h0;
	localparam logic [2:0] ADDR_DIV_HI = 3'h1;

	// Field positions
	localparam int LINE_DIV_ACCESS_BIT = 7;
	localparam int MODEM_DTR_BIT = 0;
	localparam int MODEM_RTS_BIT = 1;
	localparam int MODEM_AUX_BIT = 2;
	localparam int MODEM_INT_EN_BIT = 3;
	localparam int MODEM_LOOP_BIT = 4;
	localparam int IRQ_EN_RX_BIT = 0;
	localparam int IRQ_EN_TX_BIT = 1;
	localparam int IRQ_EN_LINE_BIT = 2;
	localparam int IRQ_EN_MODEM_BIT = 3;

	// Reset values
	localparam logic [3:0] IRQ_EN_RST = 4'h0;
	localparam logic [7:0] LINE_CTL_RST = 8'h00;
	localparam logic [4:0] MODEM_CTL_RST = 5'h00;
	localparam logic [7:0] SPR_RST = 8'hFF;
	localparam logic [15:0] DIV_RST = 16'h0000;

	// Interrupt status codes
	localparam logic [3:0] ISR_NONE = 4'h1;
	localparam logic [3:0] ISR_LINE = 4'h6;
	localparam logic [3:0] ISR_RX = 4'h4;
	localparam logic [3:0] ISR_TX_EMPTY = 4'h2;
	localparam logic [3:0] ISR_MODEM = 4'h0;

	// Oversampling: sixteen reference ticks per bit
	localparam logic [3:0] PHASE_MID = 4'h7;
	localparam logic [3:0] PHASE_LAST = 4'hF;
	localparam logic [2:0] LAST_BIT = 3'h7;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_START = 2'b01,
		TX_DATA = 2'b10,
		TX_STOP = 2'b11
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_t;

endpackage

/* logic/baud_if.sv */
/*
 Carrier between the channel logic and its baud generator.
 Assumes both ends run on the same device clock.
*/
`timescale 1ns/100ps
interface baud_if;
	logic [15:0] divisor;
	logic tick16;
	modport gen (input divisor, output tick16);
	modport user (output divisor, input tick16);
endinterface

/* logic/baud_gen.sv */
/*
 Programmable divider producing the 16x reference tick for one channel.
 Assumes the divisor is held stable by the register file.
*/
`timescale 1ns/100ps
module baud_gen (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	baud_if.gen bus
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic tick_q;
	logic tick_d;

	always_comb begin
		cnt_d = cnt_q;
		tick_d = 1'b0;
		if (bus.divisor == 16'h0000) begin
			// Zero divisor parks the generator
			cnt_d = 16'h0000;
		end else if (16'(cnt_q + 16'h0001) >= bus.divisor) begin
			cnt_d = 16'h0000;
			tick_d = 1'b1;
		end else begin
			cnt_d = 16'(cnt_q + 16'h0001);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign bus.tick16 = tick_q;
endmodule

/* tb/remote_serial_model.sv */
/*
 Remote serial device: decodes 8N1 frames from the channel, sends frames to it,
 and drives the modem pins. Assumes i_bit_cycles clocks per bit, set by the bench.
*/
`timescale 1ns/100ps
module remote_serial_model (
	input wire logic i_ref_clk,
	input wire logic i_line,
	input wire logic [15:0] i_bit_cycles,
	output logic o_line,
	output logic [3:0] o_modem_n
);
	logic [7:0] got;
	int frames;
	initial begin
		o_line = 1'b1;
		o_modem_n = 4'hF;
		got = 8'h00;
		frames = 0;
	end
	// Centre sampling, LSB first, one bit per i_bit_cycles reference clocks
	always begin
		@(negedge i_line);
		repeat (i_bit_cycles / 2) @(posedge i_ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (i_bit_cycles) @(posedge i_ref_clk);
			got[i] = i_line;
		end
		repeat (i_bit_cycles) @(posedge i_ref_clk);
		frames++;
	end
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge i_ref_clk);
			o_line = f[i];
			repeat (i_bit_cycles - 1) @(negedge i_ref_clk);
		end
	endtask
	task automatic set_modem(input logic [3:0] m);
		@(negedge i_ref_clk);
		o_modem_n = m;
	endtask
endmodule

/* tb/uart_baud_loop_asserts.sv */
/*
 Concurrent checks on the channel pins.
 Assumes binding to uart_baud_loop; shadows the CPU writes it sees.
*/
`timescale 1ns/100ps
module uart_baud_loop_asserts (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_cs_n,
	input wire logic i_wr_n,
	input wire logic i_rd_n,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] o_rdata,
	input wire logic i_rx,
	input wire logic o_tx,
	input wire logic i_cts_n,
	input wire logic i_dsr_n,
	input wire logic i_ri_n,
	input wire logic i_cd_n,
	input wire logic o_dtr_n,
	input wire logic o_rts_n,
	input wire logic o_irq
);
	logic [7:0] line_ctl_q;
	logic [7:0] lo_q;
	logic [7:0] hi_q;
	logic [4:0] modem_ctl_q;
	int low_cnt;
	logic wr;
	logic rd;
	assign wr = !i_cs_n && !i_wr_n;
	assign rd = !i_cs_n && !i_rd_n && i_wr_n;
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			line_ctl_q <= 8'h00;
			modem_ctl_q <= 5'h00;
			lo_q <= 8'h00;
			hi_q <= 8'h00;
			low_cnt <= 0;
		end else begin
			if (wr && i_addr == 3'h3) line_ctl_q <= i_wdata;
			if (wr && i_addr == 3'h4) modem_ctl_q <= i_wdata[4:0];
			if (wr && line_ctl_q[7] && i_addr == 3'h0) lo_q <= i_wdata;
			if (wr && line_ctl_q[7] && i_addr == 3'h1) hi_q <= i_wdata;
			low_cnt <= o_tx ? 0 : low_cnt + 1;
		end
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	a_loop_tx_mark: assert property (modem_ctl_q[4] && $past(modem_ctl_q[4]) |-> o_tx)
		else $error("tx pin not at mark in loop-back");
	a_loop_ctl_off: assert property (modem_ctl_q[4] && $past(modem_ctl_q[4])
		|-> o_dtr_n && o_rts_n)
		else $error("modem outputs active in loop-back");
	a_ctl_follow: assert property (!modem_ctl_q[4] && !$past(modem_ctl_q[4])
		|-> o_dtr_n == !$past(modem_ctl_q[0]) && o_rts_n == !$past(modem_ctl_q[1]))
		else $error("modem outputs do not follow control bits");
	a_irq_gated: assert property (!$past(modem_ctl_q[3]) |-> !o_irq)
		else $error("irq high while its enable bit is clear");
	a_div_lo_read: assert property (rd && line_ctl_q[7] && i_addr == 3'h0 |=> o_rdata == lo_q)
		else $error("low divisor byte read wrong");
	a_div_hi_read: assert property (rd && line_ctl_q[7] && i_addr == 3'h1 |=> o_rdata == hi_q)
		else $error("high divisor byte read wrong");
	a_rdata_hold: assert property (i_cs_n || i_rd_n |=> $stable(o_rdata))
		else $error("read data changed without a read");
	a_bit_time: assert property ($rose(o_tx) && {hi_q, lo_q} != 16'h0000
		|-> low_cnt % (16 * int'({hi_q, lo_q})) == 0)
		else $error("low run not a whole number of bit times");
	c_loop: cover property ($rose(modem_ctl_q[4]));
	c_irq: cover property ($rose(o_irq));
	c_start: cover property ($rose(o_tx) && low_cnt == 16);
endmodule
bind uart_baud_loop uart_baud_loop_asserts chk_u (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
	.i_cs_n(i_cs_n), .i_wr_n(i_wr_n), .i_rd_n(i_rd_n), .i_addr(i_addr), .i_wdata(i_wdata),
	.o_rdata(o_rdata), .i_rx(i_rx), .o_tx(o_tx), .i_cts_n(i_cts_n), .i_dsr_n(i_dsr_n),
	.i_ri_n(i_ri_n), .i_cd_n(i_cd_n), .o_dtr_n(o_dtr_n), .o_rts_n(o_rts_n), .o_irq(o_irq));

/* tb/uart_baud_loop_bench.sv */
/*
 Self-checking bench for the serial channel through its CPU register port.
 Assumes remote_serial_model on the pins and a 50 MHz device clock.
*/
`timescale 1ns/100ps
module uart_baud_loop_bench;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic cs_n = 1'b1;
	logic wr_n = 1'b1;
	logic rd_n = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic tx;
	logic rx;
	logic dtr_n;
	logic rts_n;
	logic irq;
	logic [3:0] modem_n;
	logic [15:0] bit_cycles = 16'h0010;
	logic [7:0] divs [3] = '{8'h01, 8'h03, 8'h0C};
	int bad_count = 0;
	int tests_run = 0;
	int n;
	always #10 ref_clk = ~ref_clk;
	uart_baud_loop dut_u (.i_ref_clk(ref_clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_wr_n(wr_n),
		.i_rd_n(rd_n), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_rx(rx), .o_tx(tx),
		.i_cts_n(modem_n[0]), .i_dsr_n(modem_n[1]), .i_ri_n(modem_n[2]), .i_cd_n(modem_n[3]),
		.o_dtr_n(dtr_n), .o_rts_n(rts_n), .o_irq(irq));
	remote_serial_model peer_u (.i_ref_clk(ref_clk), .i_line(tx), .i_bit_cycles(bit_cycles),
		.o_line(rx), .o_modem_n(modem_n));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic sel_n = 1'b0);
		@(negedge ref_clk);
		cs_n = sel_n;
		wr_n = 1'b0;
		addr = a;
		wdata = d;
		@(negedge ref_clk);
		cs_n = 1'b1;
		wr_n = 1'b1;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
		@(negedge ref_clk);
		cs_n = 1'b0;
		rd_n = 1'b0;
		addr = a;
		@(negedge ref_clk);
		cs_n = 1'b1;
		rd_n = 1'b1;
		check(what, rdata, exp);
	endtask
	task automatic report_and_stop;
		if (bad_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Longest test uses divisor 12: a few frames of 1920 cycles
	initial begin
		repeat (30000) @(posedge ref_clk);
		bad_count++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		rd(3'h4, 8'h00, "modem_ctl_reset");
		rd(3'h5, 8'h60, "lsr_reset");
		wr(3'h3, 8'h80, 1'b1);
		rd(3'h3, 8'h00, "line_ctl_deselected");
		wr(3'h3, 8'h80);
		wr(uart_bl_pkg::ADDR_DIV_LO, 8'h34);
		wr(uart_bl_pkg::ADDR_DIV_HI, 8'h12);
		rd(uart_bl_pkg::ADDR_DIV_LO, 8'h34, "div_lo");
		rd(uart_bl_pkg::ADDR_DIV_HI, 8'h12, "div_hi");
		wr(3'h3, 8'h00);
		rd(3'h1, 8'h00, "irq_en_not_divisor");
		for (int i = 0; i < 3; i++) begin
			wr(3'h3, 8'h80);
			wr(3'h0, divs[i]);
			wr(3'h1, 8'h00);
			wr(3'h3, 8'h00);
			bit_cycles = 16'(16 * divs[i]);
			wr(3'h0, 8'hB5);
			n = 0;
			while (tx === 1'b1 && n < 100) begin
				@(negedge ref_clk);
				n++;
			end
			n = 0;
			while (tx === 1'b0 && n < 255) begin
				@(negedge ref_clk);
				n++;
			end
			check("start_bit_cycles", 8'(n), 8'(16 * divs[i]));
			repeat (160 * divs[i]) @(negedge ref_clk);
			check("peer_byte", peer_u.got, 8'hB5);
		end
		peer_u.send(8'hA5);
		repeat (200) @(negedge ref_clk);
		rd(3'h5, 8'h61, "lsr_rx_ready");
		rd(3'h0, 8'hA5, "rx_byte");
		wr(3'h4, 8'h1F);
		repeat (2) @(negedge ref_clk);
		check("loop_pins", {5'h00, tx, dtr_n, rts_n}, 8'h07);
		rd(3'h6, 8'hFF, "msr_enter_loop");
		rd(3'h6, 8'hF0, "msr_cleared");
		peer_u.set_modem(4'h0);
		wr(3'h4, 8'h15);
		rd(3'h6, 8'h5A, "msr_loop_map");
		n = peer_u.frames;
		wr(3'h4, 8'h18);
		wr(3'h1, 8'h01);
		wr(3'h0, 8'hC3);
		repeat (2400) @(negedge ref_clk);
		check("irq_loop_rx", {7'h00, irq}, 8'h01);
		rd(3'h2, 8'h04, "isr_loop_rx");
		check("peer_frames", 8'(peer_u.frames), 8'(n));
		wr(3'h1, 8'h00);
		repeat (2) @(negedge ref_clk);
		check("irq_masked", {7'h00, irq}, 8'h00);
		rd(3'h5, 8'h61, "lsr_loop_ready");
		rd(3'h0, 8'hC3, "loop_byte");
		wr(3'h4, 8'h03);
		repeat (2) @(negedge ref_clk);
		check("ctl_pins_normal", {6'h00, dtr_n, rts_n}, 8'h00);
		rd(3'h6, 8'hFF, "msr_pins_normal");
		report_and_stop();
	end
endmodule
